// [hdl/ceag_top.sv]
// effective address and program counter advance for the cpu core
//
// Contract
// - inherent: operands from opcode only, one byte, pc advances one
// - immediate: address is pc plus one, pc advances two
// - direct: high byte zero, low byte from operand, pc advances two
// - extended: high from first operand, low from second, pc plus three
// - indexed no offset: high zero, low from index, pc plus one
// - byte offset: index plus operand, carry to high byte, pc plus two
// - word offset: index plus second byte, carry into first, pc plus 3
// - branch: pc plus two plus signed offset if taken, else pc plus two
// - branch targets span 126 below to 129 above opcode address
// - bit modify: bit from opcode, page-zero address, pc plus two
// - ten addressing modes; longest instruction is three bytes
module ceag_top
  import ceag_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  ceag_pkg::ceag_req_s   req,
  output logic                  out_valid,
  output ceag_pkg::ceag_mode_e  mode,
  output ceag_pkg::ceag_res_s   res
);
  import ceag_pkg::*;

  function automatic logic [15:0] add16(input logic [15:0] a,
                                        input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    add16 = s[15:0];
  endfunction : add16

  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction : sext8

  ceag_mode_e  mode_dec;
  ceag_res_s   res_next;
  logic        out_valid_reg;
  ceag_mode_e  mode_reg;
  ceag_res_s   res_reg;

  ceag_mode_decode u_decode (
    .opcode (req.opcode),
    .mode   (mode_dec)
  );

  wire logic [15:0] pc_p1;
  wire logic [15:0] pc_p2;
  wire logic [15:0] pc_p3;
  wire logic [15:0] rel_target;
  wire logic [15:0] btb_target;
  wire logic [8:0]  ix1_sum;
  wire logic [8:0]  ix2_lo;
  wire logic [7:0]  ix2_hi;
  wire logic [7:0]  bit_mask;

  assign pc_p1      = add16(req.pc, PC_STEP_1);
  assign pc_p2      = add16(req.pc, PC_STEP_2);
  assign pc_p3      = add16(req.pc, PC_STEP_3);
  assign rel_target = add16(pc_p2, sext8(req.oper1));
  assign btb_target = add16(pc_p3, sext8(req.oper2));
  assign ix1_sum    = {1'b0, req.index_x} + {1'b0, req.oper1};
  assign ix2_lo     = {1'b0, req.index_x} + {1'b0, req.oper2};
  assign ix2_hi     = req.oper1 + {7'h00, ix2_lo[8]};
  assign bit_mask   = BIT_ONE << req.opcode[3:1];

  // one branch per mode; longest form is three bytes
  always_comb begin
    res_next          = '0;
    res_next.bit_mask = bit_mask;
    res_next.bit_set  = ~req.opcode[0];
    case (mode_dec)
      inherent_mode: begin
        res_next.effective_address = ADDR_ZERO;
        res_next.next_pc           = pc_p1;
        res_next.instr_len         = LEN_ONE;
      end
      immediate_mode: begin
        res_next.effective_address = pc_p1;
        res_next.next_pc           = pc_p2;
        res_next.instr_len         = LEN_TWO;
      end
      direct_mode: begin
        res_next.effective_address = {PAGE_ZERO, req.oper1};
        res_next.next_pc           = pc_p2;
        res_next.instr_len         = LEN_TWO;
      end
      extended_mode: begin
        res_next.effective_address = {req.oper1, req.oper2};
        res_next.next_pc           = pc_p3;
        res_next.instr_len         = LEN_THREE;
      end
      indexed_mode: begin
        res_next.effective_address = {PAGE_ZERO, req.index_x};
        res_next.next_pc           = pc_p1;
        res_next.instr_len         = LEN_ONE;
      end
      indexed_byte_offset_mode: begin
        res_next.effective_address = {7'h00, ix1_sum};
        res_next.next_pc           = pc_p2;
        res_next.instr_len         = LEN_TWO;
      end
      indexed_word_offset_mode: begin
        res_next.effective_address = {ix2_hi, ix2_lo[7:0]};
        res_next.next_pc           = pc_p3;
        res_next.instr_len         = LEN_THREE;
      end
      pc_relative_mode: begin
        res_next.effective_address = req.branch_cond ? rel_target : pc_p2;
        res_next.next_pc           = req.branch_cond ? rel_target : pc_p2;
        res_next.instr_len         = LEN_TWO;
      end
      bit_modify_mode: begin
        res_next.effective_address = {PAGE_ZERO, req.oper1};
        res_next.next_pc           = pc_p2;
        res_next.instr_len         = LEN_TWO;
      end
      bit_test_branch_mode: begin
        res_next.effective_address = {PAGE_ZERO, req.oper1};
        res_next.next_pc           = req.branch_cond ? btb_target : pc_p3;
        res_next.instr_len         = LEN_THREE;
      end
      default: begin
        res_next.effective_address = ADDR_ZERO;
        res_next.next_pc           = pc_p1;
        res_next.instr_len         = LEN_ONE;
      end
    endcase
  end

  // results held until the next request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid_reg <= 1'b0;
      mode_reg      <= inherent_mode;
      res_reg       <= '0;
    end else begin
      out_valid_reg <= in_valid;
      if (in_valid) begin
        mode_reg <= mode_dec;
        res_reg  <= res_next;
      end
    end
  end

  assign out_valid = out_valid_reg;
  assign mode      = mode_reg;
  assign res       = res_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_inherent;
    in_valid && (req.opcode[7:4] == NIB_INH_A) |=>
      out_valid && res.instr_len == LEN_ONE &&
      res.next_pc == $past(req.pc) + PC_STEP_1;
  endproperty
  a_inherent: assert property (p_inherent)
    else $error("inherent instruction not one byte");

  property p_immediate;
    in_valid && mode_dec == immediate_mode |=>
      res.effective_address == $past(req.pc) + PC_STEP_1 &&
      res.next_pc == $past(req.pc) + PC_STEP_2;
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("immediate address or pc step wrong");

  property p_direct;
    in_valid && mode_dec == direct_mode |=>
      res.effective_address == {PAGE_ZERO, $past(req.oper1)} &&
      res.next_pc == $past(req.pc) + PC_STEP_2;
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct address not in page zero");

  property p_extended;
    in_valid && mode_dec == extended_mode |=>
      res.effective_address == {$past(req.oper1), $past(req.oper2)} &&
      res.next_pc == $past(req.pc) + PC_STEP_3;
  endproperty
  a_extended: assert property (p_extended)
    else $error("extended address byte order wrong");

  property p_indexed;
    in_valid && mode_dec == indexed_mode |=>
      res.effective_address == {PAGE_ZERO, $past(req.index_x)} &&
      res.next_pc == $past(req.pc) + PC_STEP_1;
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed address not from index");

  property p_byte_offset;
    in_valid && mode_dec == indexed_byte_offset_mode |=>
      res.effective_address ==
        {8'h00, $past(req.index_x)} + {8'h00, $past(req.oper1)} &&
      res.next_pc == $past(req.pc) + PC_STEP_2;
  endproperty
  a_byte_offset: assert property (p_byte_offset)
    else $error("byte offset sum wrong");

  property p_word_offset;
    in_valid && mode_dec == indexed_word_offset_mode |=>
      res.effective_address == {$past(req.oper1), $past(req.oper2)} +
        {8'h00, $past(req.index_x)} &&
      res.next_pc == $past(req.pc) + PC_STEP_3;
  endproperty
  a_word_offset: assert property (p_word_offset)
    else $error("word offset sum wrong");

  property p_branch;
    in_valid && mode_dec == pc_relative_mode |=>
      res.next_pc == ($past(req.branch_cond) ?
        $past(req.pc) + PC_STEP_2 + sext8($past(req.oper1)) :
        $past(req.pc) + PC_STEP_2);
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch target wrong");

  property p_span;
    out_valid && mode == pc_relative_mode && $past(in_valid) |->
      $signed(16'(res.next_pc - $past(req.pc))) >= REL_SPAN_LO &&
      $signed(16'(res.next_pc - $past(req.pc))) <= REL_SPAN_HI;
  endproperty
  a_span: assert property (p_span)
    else $error("branch outside span");

  property p_bit_modify;
    in_valid && mode_dec == bit_modify_mode |=>
      res.effective_address == {PAGE_ZERO, $past(req.oper1)} &&
      res.bit_mask == (BIT_ONE << $past(req.opcode[3:1])) &&
      res.next_pc == $past(req.pc) + PC_STEP_2;
  endproperty
  a_bit_modify: assert property (p_bit_modify)
    else $error("bit modify target wrong");

  property p_modes;
    out_valid |-> $onehot(mode) && res.instr_len != 2'h0;
  endproperty
  a_modes: assert property (p_modes)
    else $error("mode not one of ten or bad length");

  property p_wrap;
    in_valid && req.pc == 16'hFFFF && mode_dec == extended_mode |=>
      res.next_pc == PC_STEP_2;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pc did not wrap");

  c_taken: cover property (in_valid && mode_dec == pc_relative_mode &&
                           req.branch_cond);
  c_ix1_carry: cover property (in_valid && ix1_sum[8] &&
                               mode_dec == indexed_byte_offset_mode);
  c_ix2_carry: cover property (in_valid && ix2_lo[8] &&
                               mode_dec == indexed_word_offset_mode);
  c_back2back: cover property (in_valid [*3]);

endmodule : ceag_top

// [hdl/ceag_pkg.sv]
// shared constants and types for the effective address generator
package ceag_pkg;

  localparam int          ADDR_W     = 16;
  localparam int          BYTE_W     = 8;

  // opcode high nibble groups
  localparam logic [3:0]  NIB_BTB    = 4'h0;
  localparam logic [3:0]  NIB_BSC    = 4'h1;
  localparam logic [3:0]  NIB_REL    = 4'h2;
  localparam logic [3:0]  NIB_DIR_RM = 4'h3;
  localparam logic [3:0]  NIB_INH_A  = 4'h4;
  localparam logic [3:0]  NIB_INH_X  = 4'h5;
  localparam logic [3:0]  NIB_IX1_RM = 4'h6;
  localparam logic [3:0]  NIB_IX_RM  = 4'h7;
  localparam logic [3:0]  NIB_CTL_0  = 4'h8;
  localparam logic [3:0]  NIB_CTL_1  = 4'h9;
  localparam logic [3:0]  NIB_IMM    = 4'hA;
  localparam logic [3:0]  NIB_DIR    = 4'hB;
  localparam logic [3:0]  NIB_EXT    = 4'hC;
  localparam logic [3:0]  NIB_IX2    = 4'hD;
  localparam logic [3:0]  NIB_IX1    = 4'hE;
  localparam logic [3:0]  NIB_IX     = 4'hF;

  // program counter steps
  localparam logic [15:0] PC_STEP_1  = 16'h0001;
  localparam logic [15:0] PC_STEP_2  = 16'h0002;
  localparam logic [15:0] PC_STEP_3  = 16'h0003;

  localparam logic [1:0]  LEN_ONE    = 2'h1;
  localparam logic [1:0]  LEN_TWO    = 2'h2;
  localparam logic [1:0]  LEN_THREE  = 2'h3;

  localparam logic [7:0]  PAGE_ZERO  = 8'h00;
  localparam logic [7:0]  BIT_ONE    = 8'h01;
  localparam logic [15:0] ADDR_ZERO  = 16'h0000;

  // branch span limits from the opcode address
  localparam int          REL_SPAN_LO = -126;
  localparam int          REL_SPAN_HI = 129;

  typedef enum logic [9:0] {
    inherent_mode            = 10'h001,
    immediate_mode           = 10'h002,
    direct_mode              = 10'h004,
    extended_mode            = 10'h008,
    indexed_mode             = 10'h010,
    indexed_byte_offset_mode = 10'h020,
    indexed_word_offset_mode = 10'h040,
    pc_relative_mode         = 10'h080,
    bit_modify_mode          = 10'h100,
    bit_test_branch_mode     = 10'h200
  } ceag_mode_e;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  oper1;
    logic [7:0]  oper2;
    logic [15:0] pc;
    logic [7:0]  index_x;
    logic        branch_cond;
  } ceag_req_s;

  typedef struct packed {
    logic [15:0] effective_address;
    logic [15:0] next_pc;
    logic [1:0]  instr_len;
    logic [7:0]  bit_mask;
    logic        bit_set;
  } ceag_res_s;

endpackage : ceag_pkg

// [hdl/ceag_mode_decode.sv]
// addressing mode decode from the opcode high nibble
module ceag_mode_decode
  import ceag_pkg::*;
(
  input  wire logic [7:0] opcode,
  output ceag_mode_e      mode
);

  wire logic [3:0] nib;
  wire logic       is_inh;
  wire logic       is_dir;
  wire logic       is_ix1;
  wire logic       is_ix;

  assign nib    = opcode[7:4];
  assign is_inh = (nib == NIB_INH_A) || (nib == NIB_INH_X) ||
                  (nib == NIB_CTL_0) || (nib == NIB_CTL_1);
  assign is_dir = (nib == NIB_DIR_RM) || (nib == NIB_DIR);
  assign is_ix1 = (nib == NIB_IX1_RM) || (nib == NIB_IX1);
  assign is_ix  = (nib == NIB_IX_RM)  || (nib == NIB_IX);

  assign mode = is_inh           ? inherent_mode            :
                (nib == NIB_IMM) ? immediate_mode           :
                is_dir           ? direct_mode              :
                (nib == NIB_EXT) ? extended_mode            :
                is_ix            ? indexed_mode             :
                is_ix1           ? indexed_byte_offset_mode :
                (nib == NIB_IX2) ? indexed_word_offset_mode :
                (nib == NIB_REL) ? pc_relative_mode         :
                (nib == NIB_BSC) ? bit_modify_mode          :
                                   bit_test_branch_mode;

endmodule : ceag_mode_decode

// [dv/ceag_mem_model.sv]
// memory model supplying the opcode stream bytes after the opcode
module ceag_mem_model (
  input  wire logic [15:0] pc,
  output logic      [7:0]  oper1,
  output logic      [7:0]  oper2
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:65535];
  logic [15:0] addr1;
  logic [15:0] addr2;
  // unwritten bytes read as a fill pattern, never unknown
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hA5;
    end
  end
  // fetch addresses wrap at the top of memory
  assign addr1 = pc + 16'h0001;
  assign addr2 = pc + 16'h0002;
  assign oper1 = mem[addr1];
  assign oper2 = mem[addr2];
endmodule : ceag_mem_model

// [dv/ceag_top_tb.sv]
// self-checking bench for the effective address generator
module ceag_top_tb import ceag_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       in_valid = 1'b0;
  ceag_req_s  req_d = '0;
  ceag_req_s  req;
  logic [7:0] oper1;
  logic [7:0] oper2;
  logic       out_valid;
  ceag_mode_e mode;
  ceag_res_s  res;
  int         num_errors = 0;
  int         check_count = 0;

  always #25 clk = ~clk;
  always_comb begin
    req = req_d;
    req.oper1 = oper1;
    req.oper2 = oper2;
  end

  ceag_mem_model u_mem (.pc(req_d.pc), .oper1(oper1), .oper2(oper2));
  ceag_top u_dut (.clk(clk), .rst(rst), .in_valid(in_valid), .req(req),
                  .out_valid(out_valid), .mode(mode), .res(res));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic drive(input logic [7:0] opc, input logic [15:0] pc,
                       input logic [7:0] b1, input logic [7:0] b2,
                       input logic [7:0] x, input logic cond);
    u_mem.mem[pc + 16'h0001] = b1;
    u_mem.mem[pc + 16'h0002] = b2;
    in_valid = 1'b1;
    req_d = '{opc, 8'h00, 8'h00, pc, x, cond};
  endtask : drive

  task automatic issue(input logic [7:0] opc, input logic [15:0] pc,
                       input logic [7:0] b1, input logic [7:0] b2,
                       input logic [7:0] x, input logic cond);
    @(negedge clk);
    drive(opc, pc, b1, b2, x, cond);
    @(negedge clk);
    in_valid = 1'b0;
    chk({15'h0, out_valid}, 16'h0001);
  endtask : issue

  task automatic expect_res(input ceag_mode_e m, input logic [15:0] ea,
                            input logic [15:0] npc, input logic [1:0] len);
    chk({6'h00, mode}, {6'h00, m});
    chk(res.effective_address, ea);
    chk(res.next_pc, npc);
    chk({14'h0, res.instr_len}, {14'h0, len});
  endtask : expect_res

  task automatic check_idle();
    chk({15'h0, out_valid}, 16'h0000);
    chk({6'h00, mode}, {6'h00, inherent_mode});
    chk(res.effective_address, 16'h0000);
    chk(res.next_pc, 16'h0000);
    chk({5'h00, res.instr_len, res.bit_mask, res.bit_set}, 16'h0000);
  endtask : check_idle

  task automatic t_inherent();
    logic [3:0] nibs [4] = '{4'h4, 4'h5, 4'h8, 4'h9};
    foreach (nibs[i]) begin
      issue({nibs[i], 4'h8}, 16'h1234, 8'h77, 8'h66, 8'h55, 1'b1);
      expect_res(inherent_mode, 16'h0000, 16'h1235, 2'h1);
    end
    $display("inherent done");
  endtask : t_inherent

  task automatic t_memory_modes();
    issue(8'hA6, 16'hFFFF, 8'h5A, 8'h3C, 8'h10, 1'b0);
    expect_res(immediate_mode, 16'h0000, 16'h0001, 2'h2);
    issue(8'hB6, 16'h0200, 8'hC3, 8'h99, 8'h10, 1'b0);
    expect_res(direct_mode, 16'h00C3, 16'h0202, 2'h2);
    issue(8'h3A, 16'h0210, 8'hFF, 8'h99, 8'h10, 1'b0);
    expect_res(direct_mode, 16'h00FF, 16'h0212, 2'h2);
    issue(8'hC6, 16'hFFFE, 8'h12, 8'h34, 8'h10, 1'b0);
    expect_res(extended_mode, 16'h1234, 16'h0001, 2'h3);
    issue(8'hC6, 16'hFFFF, 8'h56, 8'h78, 8'h10, 1'b0);
    expect_res(extended_mode, 16'h5678, 16'h0002, 2'h3);
    $display("memory modes done");
  endtask : t_memory_modes

  task automatic t_indexed();
    issue(8'hF7, 16'h0300, 8'h12, 8'h34, 8'hFF, 1'b0);
    expect_res(indexed_mode, 16'h00FF, 16'h0301, 2'h1);
    issue(8'h7C, 16'h0310, 8'h12, 8'h34, 8'h00, 1'b0);
    expect_res(indexed_mode, 16'h0000, 16'h0311, 2'h1);
    issue(8'hE6, 16'h0400, 8'hFF, 8'h34, 8'hFF, 1'b0);
    expect_res(indexed_byte_offset_mode, 16'h01FE, 16'h0402, 2'h2);
    issue(8'h6C, 16'h0410, 8'h01, 8'h34, 8'h02, 1'b0);
    expect_res(indexed_byte_offset_mode, 16'h0003, 16'h0412, 2'h2);
    issue(8'hD6, 16'h0500, 8'h12, 8'hF0, 8'h20, 1'b0);
    expect_res(indexed_word_offset_mode, 16'h1310, 16'h0503, 2'h3);
    issue(8'hD6, 16'hFFFD, 8'hFF, 8'hFF, 8'h01, 1'b0);
    expect_res(indexed_word_offset_mode, 16'h0000, 16'h0000, 2'h3);
    $display("indexed done");
  endtask : t_indexed

  task automatic t_relative();
    logic [7:0]  offs [3] = '{8'h7F, 8'h80, 8'h05};
    logic        cond [3] = '{1'b1, 1'b1, 1'b0};
    logic [15:0] dest [3] = '{16'h0881, 16'h0782, 16'h0802};
    foreach (offs[i]) begin
      issue(8'h26, 16'h0800, offs[i], 8'h00, 8'h10, cond[i]);
      expect_res(pc_relative_mode, dest[i], dest[i], 2'h2);
    end
    $display("relative done");
  endtask : t_relative

  task automatic t_bit_modes();
    logic [7:0] opc;
    for (int i = 0; i < 16; i++) begin
      opc = 8'h10 + 8'(i);
      issue(opc, 16'h0900, 8'h4C, 8'h00, 8'h10, 1'b0);
      expect_res(bit_modify_mode, 16'h004C, 16'h0902, 2'h2);
      chk({7'h0, res.bit_set, res.bit_mask},
          {7'h0, ~opc[0], 8'h01 << opc[3:1]});
    end
    issue(8'h0E, 16'h0A00, 8'h33, 8'hFE, 8'h10, 1'b1);
    expect_res(bit_test_branch_mode, 16'h0033, 16'h0A01, 2'h3);
    issue(8'h0F, 16'h0A00, 8'h33, 8'hFE, 8'h10, 1'b0);
    expect_res(bit_test_branch_mode, 16'h0033, 16'h0A03, 2'h3);
    $display("bit modes done");
  endtask : t_bit_modes

  task automatic t_back_to_back();
    @(negedge clk);
    drive(8'hC6, 16'h0B00, 8'hAB, 8'hCD, 8'h10, 1'b0);
    @(negedge clk);
    chk({15'h0, out_valid}, 16'h0001);
    expect_res(extended_mode, 16'hABCD, 16'h0B03, 2'h3);
    drive(8'hE6, 16'h0C00, 8'h80, 8'h00, 8'h90, 1'b0);
    @(negedge clk);
    chk({15'h0, out_valid}, 16'h0001);
    expect_res(indexed_byte_offset_mode, 16'h0110, 16'h0C02, 2'h2);
    drive(8'hB6, 16'h0D00, 8'h44, 8'h00, 8'h90, 1'b0);
    @(negedge clk);
    in_valid = 1'b0;
    chk({15'h0, out_valid}, 16'h0001);
    expect_res(direct_mode, 16'h0044, 16'h0D02, 2'h2);
    @(negedge clk);
    chk({15'h0, out_valid}, 16'h0000);
    rst = 1'b1;
    @(negedge clk);
    check_idle();
    rst = 1'b0;
    $display("back to back and reset done");
  endtask : t_back_to_back

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #(2000 * 50);
    num_errors++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check_idle();
    t_inherent();
    t_memory_modes();
    t_indexed();
    t_relative();
    t_bit_modes();
    t_back_to_back();
    finish_test();
  end
endmodule : ceag_top_tb
